/* File: rtl/imw_column.sv */
// Purpose: One 16-bit wide memory column with separate read and write ports
// Assumes: Read data is registered, one cycle after the address
// Notes:   No reset on the storage
`include "imw_params.svh"
module imw_column (
   input  wire logic                      hclk,
   input  wire logic                      we,
   input  wire logic [`IMW_ROW_BITS-1:0]  waddr,
   input  wire logic [`IMW_COL_BITS-1:0]  wdata,
   input  wire logic [`IMW_ROW_BITS-1:0]  raddr,
   output logic      [`IMW_COL_BITS-1:0]  rdata
);
   logic [`IMW_COL_BITS-1:0] mem [`IMW_ROWS];

   // Committed writes from the shadow buffer
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Synchronous read
   always_ff @(posedge hclk) begin
      rdata <= mem[raddr];
   end
endmodule

/* File: rtl/imw_mapper.sv */
// Purpose: Access width choice and column mapping of one internal memory block
// Assumes: One core access per cycle; reads answer two cycles later
// Notes:   Control and status reach software over an AHB-Lite slave
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`include "imw_params.svh"
module imw_mapper (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                core_req,
   input  wire logic                core_fetch,
   input  wire logic                core_write,
   input  wire logic                core_short,
   input  wire logic                core_data_memory_bus,
   input  wire logic                core_px,
   input  wire logic [16:0]         core_addr,
   input  wire logic [47:0]         core_wdata,
   output logic                     core_rvalid,
   output logic      [47:0]         core_rdata,
   output logic      [31:0]         core_reg_data,
   output imw_pkg::imw_width_t      core_width
);
   // Bus slave state
   logic        ap_valid;
   logic        ap_write;
   logic [7:0]  ap_addr;
   logic        width_sel;
   logic        short_sign_extend;
   // Access decode
   imw_pkg::imw_width_t acc_w;
   logic [15:0] sc_norm;
   logic        sc_half;
   logic [15:0] acc_addr;
   logic [2:0]  acc_grp;
   logic        acc_nomap;
   logic [17:0] acc_key;
   logic [47:0] acc_data;
   // Shadow buffer, entry 0 is the newest
   logic                f_v    [2];
   logic [17:0]         f_key  [2];
   logic [47:0]         f_data [2];
   logic [12:0]         f_row  [2];
   logic [2:0]          f_grp  [2];
   logic                f_half [2];
   logic                f_nomap[2];
   imw_pkg::imw_width_t f_w    [2];
   logic        hit0;
   logic        hit1;
   logic        commit;
   // Columns
   logic [`IMW_COLS-1:0] col_we;
   logic [15:0] col_wd [`IMW_COLS];
   logic [15:0] col_q  [`IMW_COLS];
   // Read stage
   logic                s_valid;
   imw_pkg::imw_width_t s_w;
   logic [2:0]          s_grp;
   logic                s_half;
   logic                s_nomap;
   logic                s_hit;
   logic [47:0]         s_hitdata;
   logic                s_px;
   logic [47:0]         s_img;
   logic [47:0]         next_rdata;
   logic [31:0]         sc_wide;
   logic                o_px;
   logic                o_sse;

   // Trim a raw 48-bit image to what the access width carries
   function automatic logic [47:0] imw_shape(input logic [47:0] d, input imw_pkg::imw_width_t w);
      logic [47:0] r;
      r = d;
      unique case (w)
         imw_pkg::IMW_W48: r = d;
         imw_pkg::IMW_W40: r = {d[47:8], 8'h00};
         imw_pkg::IMW_W32: r = {d[47:16], 16'h0000};
         imw_pkg::IMW_W16: r = {16'h0000, d[31:16], 16'h0000};
      endcase
      return r;
   endfunction

   // AHB address phase capture; slave never stalls and always answers OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 8'h00;
      end else begin
         ap_valid <= hsel && hready && htrans[1];
         ap_write <= hwrite;
         ap_addr  <= haddr[7:0];
      end
   end

   // Control register write in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         width_sel <= 1'b0;
         short_sign_extend       <= 1'b0;
      end else if (ap_valid && ap_write && ap_addr == `IMW_OFF_CTRL) begin
         width_sel <= hwdata[`IMW_CTRL_WIDTH];
         short_sign_extend       <= hwdata[`IMW_CTRL_SSE];
      end
   end

   // Read data from register state; unmapped offsets read zero
   always_comb begin
      hrdata = 32'h0000_0000;
      if (ap_valid && !ap_write) begin
         if (ap_addr == `IMW_OFF_CTRL) begin
            hrdata[`IMW_CTRL_WIDTH] = width_sel;
            hrdata[`IMW_CTRL_SSE]   = short_sign_extend;
         end else if (ap_addr == `IMW_OFF_STAT) begin
            hrdata[`IMW_STAT_WMSB:`IMW_STAT_WLSB] = core_width;
            hrdata[`IMW_STAT_NOMAP]              = s_nomap;
            hrdata[`IMW_STAT_F0]                 = f_v[0];
            hrdata[`IMW_STAT_F1]                 = f_v[1];
         end
      end
   end

   // Short address conversion and read widening
   imw_short_conv u_short (
      .short_addr (core_addr),
      .norm_addr  (sc_norm),
      .half_sel   (sc_half),
      .half_word  (next_rdata[31:16]),
      .short_sign_extend        (short_sign_extend),
      .to_px      (s_px),
      .widened    (sc_wide)
   );

   // Width choice, highest priority first
   always_comb begin
      if (core_fetch) begin
         acc_w = imw_pkg::IMW_W48;
      end else if (core_short) begin
         acc_w = imw_pkg::IMW_W16;
      end else if (core_px) begin
         acc_w = core_data_memory_bus ? imw_pkg::IMW_W40 : imw_pkg::IMW_W48;
      end else begin
         acc_w = width_sel ? imw_pkg::IMW_W40 : imw_pkg::IMW_W32;
      end
   end

   // Group and row split; 48-bit groups above the fifth hold no storage
   assign acc_addr  = (core_short && !core_fetch) ? sc_norm : core_addr[15:0];
   assign acc_grp   = acc_addr[`IMW_GRP_MSB:`IMW_GRP_LSB];
   assign acc_nomap = (acc_w == imw_pkg::IMW_W48 || acc_w == imw_pkg::IMW_W40)
                      && acc_grp >= 3'(`IMW_G48_NUM);
   assign acc_key   = (core_short && !core_fetch) ? {1'b1, core_addr} : {2'b00, core_addr[15:0]};
   assign acc_data  = imw_shape(core_wdata, acc_w);

   // Shadow buffer lookup; it compares addresses only, not word mapping
   assign hit0   = f_v[0] && f_key[0] == acc_key;
   assign hit1   = f_v[1] && f_key[1] == acc_key;
   assign commit = core_req && core_write && f_v[1];

   // Shadow buffer: new write enters, oldest entry leaves for the array
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int e = 0; e < 2; e++) begin
            f_v[e]     <= 1'b0;
            f_key[e]   <= 18'h0_0000;
            f_data[e]  <= 48'h0000_0000_0000;
            f_row[e]   <= 13'h0000;
            f_grp[e]   <= 3'h0;
            f_half[e]  <= 1'b0;
            f_nomap[e] <= 1'b0;
            f_w[e]     <= imw_pkg::IMW_W32;
         end
      end else if (core_req && core_write) begin
         f_v[1]     <= f_v[0];
         f_key[1]   <= f_key[0];
         f_data[1]  <= f_data[0];
         f_row[1]   <= f_row[0];
         f_grp[1]   <= f_grp[0];
         f_half[1]  <= f_half[0];
         f_nomap[1] <= f_nomap[0];
         f_w[1]     <= f_w[0];
         f_v[0]     <= 1'b1;
         f_key[0]   <= acc_key;
         f_data[0]  <= acc_data;
         f_row[0]   <= acc_addr[`IMW_ROW_BITS-1:0];
         f_grp[0]   <= acc_grp;
         f_half[0]  <= sc_half;
         f_nomap[0] <= acc_nomap;
         f_w[0]     <= acc_w;
      end
   end

   // Column enables for the committed entry
   always_comb begin
      int b48;
      int b32;
      b48 = int'(f_grp[1]) * `IMW_G48_COLS;
      b32 = int'(f_grp[1]) * `IMW_G32_COLS;
      for (int c = 0; c < `IMW_COLS; c++) begin
         col_we[c] = 1'b0;
         col_wd[c] = f_data[1][31:16];
         if (commit) begin
            unique case (f_w[1])
               imw_pkg::IMW_W48, imw_pkg::IMW_W40: begin
                  if (!f_nomap[1] && c >= b48 && c < b48 + `IMW_G48_COLS) begin
                     col_we[c] = 1'b1;
                     col_wd[c] = f_data[1][(c - b48) * 16 +: 16];
                  end
               end
               imw_pkg::IMW_W32: begin
                  if (c >= b32 && c < b32 + `IMW_G32_COLS) begin
                     col_we[c] = 1'b1;
                     col_wd[c] = f_data[1][(c - b32) * 16 + 16 +: 16];
                  end
               end
               imw_pkg::IMW_W16: begin
                  if (c == b32 + int'(f_half[1])) begin
                     col_we[c] = 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Sixteen columns of 16 bits
   for (genvar g = 0; g < `IMW_COLS; g++) begin : g_col
      imw_column u_col (
         .hclk  (hclk),
         .we    (col_we[g]),
         .waddr (f_row[1]),
         .wdata (col_wd[g]),
         .raddr (acc_addr[`IMW_ROW_BITS-1:0]),
         .rdata (col_q[g])
      );
   end

   // Read stage, aligned with the column read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_valid   <= 1'b0;
         s_w       <= imw_pkg::IMW_W32;
         s_grp     <= 3'h0;
         s_half    <= 1'b0;
         s_nomap   <= 1'b0;
         s_hit     <= 1'b0;
         s_hitdata <= 48'h0000_0000_0000;
         s_px      <= 1'b0;
      end else begin
         s_valid   <= core_req && !core_write;
         s_w       <= acc_w;
         s_grp     <= acc_grp;
         s_half    <= sc_half;
         s_nomap   <= acc_nomap;
         s_hit     <= hit0 || hit1;
         s_hitdata <= hit0 ? f_data[0] : f_data[1];
         s_px      <= core_px;
      end
   end

   // Gather the selected columns into a 48-bit image
   always_comb begin
      int b48;
      int b32;
      b48 = int'(s_grp) * `IMW_G48_COLS;
      b32 = int'(s_grp) * `IMW_G32_COLS;
      s_img = 48'h0000_0000_0000;
      unique case (s_w)
         imw_pkg::IMW_W48, imw_pkg::IMW_W40: begin
            if (!s_nomap) begin
               s_img = {col_q[b48 + 2], col_q[b48 + 1], col_q[b48]};
            end
         end
         imw_pkg::IMW_W32: s_img = {col_q[b32 + 1], col_q[b32], 16'h0000};
         imw_pkg::IMW_W16: s_img = {16'h0000, col_q[b32 + int'(s_half)], 16'h0000};
      endcase
      next_rdata = imw_shape(s_hit ? s_hitdata : s_img, s_w);
   end

   // Registered answer to the core
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_rvalid   <= 1'b0;
         core_rdata    <= 48'h0000_0000_0000;
         core_reg_data <= 32'h0000_0000;
         core_width    <= imw_pkg::IMW_W32;
         o_px          <= 1'b0;
         o_sse         <= 1'b0;
      end else begin
         core_rvalid   <= s_valid;
         core_rdata    <= next_rdata;
         core_reg_data <= (s_w == imw_pkg::IMW_W16) ? sc_wide : next_rdata[47:16];
         core_width    <= s_w;
         o_px          <= s_px;
         o_sse         <= short_sign_extend;
      end
   end

   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence rd_req;
      core_req && !core_write;
   endsequence
   sequence two_writes;
      core_req && core_write ##1 core_req && core_write;
   endsequence
   sequence short_out;
      core_rvalid && core_width == imw_pkg::IMW_W16;
   endsequence

   a_fetch_width: assert property (rd_req and core_fetch |-> ##2 core_width == imw_pkg::IMW_W48)
      else $error("fetch not 48 bits");
   a_data_width: assert property (rd_req and !core_fetch && !core_short && !core_px |-> ##2
      core_width == ($past(width_sel, 2) ? imw_pkg::IMW_W40 : imw_pkg::IMW_W32))
      else $error("data width does not follow block setting");
   a_short_width: assert property (rd_req and core_short && !core_fetch |-> ##2 core_width == imw_pkg::IMW_W16)
      else $error("short access not 16 bits");
   a_px_buses: assert property (rd_req and core_px && !core_short && !core_fetch |-> ##2
      core_width == ($past(core_data_memory_bus, 2) ? imw_pkg::IMW_W40 : imw_pkg::IMW_W48))
      else $error("exchange register width wrong");
   a_forty_low: assert property (core_rvalid && core_width == imw_pkg::IMW_W40 |-> core_rdata[7:0] == 8'h00)
      else $error("40-bit low byte not zero");
   a_short_lanes: assert property (short_out |-> core_rdata[47:32] == 16'h0000 && core_rdata[15:0] == 16'h0000)
      else $error("short word off lanes 31 to 16");
   a_sign_ext: assert property (short_out and !o_px && o_sse |-> core_reg_data[31:16] == {16{core_reg_data[15]}})
      else $error("short word not sign extended");
   a_px_zero: assert property (short_out and o_px |-> core_reg_data[31:16] == 16'h0000
      && core_reg_data[15:0] == core_rdata[31:16])
      else $error("exchange register short read not zero filled");
   a_read_latency: assert property (rd_req |-> ##2 core_rvalid)
      else $error("read answer missing");
   a_shadow_full: assert property (two_writes |=> f_v[0] && f_v[1])
      else $error("shadow buffer not holding two writes");
   a_group48_cols: assert property (commit && !f_nomap[1] && f_w[1] == imw_pkg::IMW_W48 |-> $countones(col_we) == 3)
      else $error("48-bit write not three columns");
   a_group32_cols: assert property (commit && f_w[1] == imw_pkg::IMW_W32 |-> $countones(col_we) == 2)
      else $error("32-bit write not two columns");
   a_short_col: assert property (commit && f_w[1] == imw_pkg::IMW_W16 |-> $onehot(col_we))
      else $error("short write not one column");
   a_nomap_zero: assert property (rd_req and acc_nomap && !hit0 && !hit1 |-> ##2 core_rdata == 48'h0000_0000_0000)
      else $error("unmapped 48-bit read not zero");
endmodule

/* File: rtl/imw_params.svh */
// Purpose: Named constants of the internal memory word width mapper
// Assumes: One memory block, large variant (8K rows per column)
// Notes:   Small variant uses 4096 rows and 12 row bits
`ifndef IMW_PARAMS_SVH
`define IMW_PARAMS_SVH

// Column geometry
`define IMW_COLS       16
`define IMW_COL_BITS   16
`define IMW_ROWS       8192
`define IMW_ROW_BITS   13
`define IMW_GRP_LSB    13
`define IMW_GRP_MSB    15
`define IMW_G48_COLS   3
`define IMW_G32_COLS   2
`define IMW_G48_NUM    5

// Register map (byte offsets on the bus)
`define IMW_OFF_CTRL   8'h00
`define IMW_OFF_STAT   8'h04

// Control register fields
`define IMW_CTRL_WIDTH 0
`define IMW_CTRL_SSE   1

// Status register fields
`define IMW_STAT_WLSB  0
`define IMW_STAT_WMSB  1
`define IMW_STAT_NOMAP 2
`define IMW_STAT_F0    3
`define IMW_STAT_F1    4

`endif

/* File: rtl/imw_pkg.sv */
// Purpose: Types shared by the word width mapper files
// Assumes: Nothing
// Notes:   Access width codes also show in the status register
package imw_pkg;
   typedef enum logic [1:0] {
      IMW_W16 = 2'b00,
      IMW_W32 = 2'b01,
      IMW_W40 = 2'b10,
      IMW_W48 = 2'b11
   } imw_width_t;
endpackage

/* File: rtl/imw_short_conv.sv */
// Purpose: Short word address conversion and 16-to-32 bit read widening
// Assumes: Purely combinational
// Notes:   Bit shifted out of the address picks the half of the word
module imw_short_conv (
   input  wire logic [16:0] short_addr,
   output logic      [15:0] norm_addr,
   output logic             half_sel,
   input  wire logic [15:0] half_word,
   input  wire logic        short_sign_extend,
   input  wire logic        to_px,
   output logic      [31:0] widened
);
   // Right shift by one gives the normal word address
   assign norm_addr = short_addr[16:1];
   assign half_sel  = short_addr[0];

   // Zero fill into the exchange register, else sign control decides
   assign widened = (short_sign_extend && !to_px) ? {{16{half_word[15]}}, half_word}
                                    : {16'h0000, half_word};
endmodule

/* File: sim/imw_core_model.sv */
// Purpose: Core side model issuing program and data memory bus accesses
// Assumes: Each call is made just after a rising edge of hclk
// Notes:   One access per call; idle drops the request and scrambles the lines
module imw_core_model (
   input  wire logic        hclk,
   output logic             core_req,
   output logic             core_fetch,
   output logic             core_write,
   output logic             core_short,
   output logic             core_data_memory_bus,
   output logic             core_px,
   output logic      [16:0] core_addr,
   output logic      [47:0] core_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet port at time zero
   initial begin
      {core_req, core_fetch, core_write, core_short, core_data_memory_bus, core_px} = 6'h00;
      core_addr = 17'h0_0000;
      core_wdata = 48'h0000_0000_0000;
   end

   // One request, held for exactly one sampling edge
   task automatic access(input logic [4:0] k, input logic [16:0] a, input logic [47:0] d);
      {core_fetch, core_write, core_short, core_data_memory_bus, core_px} <= k;
      core_req <= 1'h1;
      core_addr <= a;
      core_wdata <= d;
      @(posedge hclk);
   endtask

   // Released lines show the inverse of their last value
   task automatic idle();
      core_req <= 1'h0;
      core_addr <= ~core_addr;
      core_wdata <= ~core_wdata;
   endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the word width mapper
// Assumes: Core model drives the access port, the bench speaks AHB-Lite
// Notes:   Reference columns kept in an associative array, reads checked in order
`include "imw_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [47:0]         rd;
      logic [31:0]         rg;
      imw_pkg::imw_width_t w;
   } imw_exp_t;

   logic                hclk = 1'h0;
   logic                hresetn = 1'h0;
   logic                hsel = 1'h0;
   logic [31:0]         haddr = 32'h0000_0000;
   logic [1:0]          htrans = 2'h0;
   logic                hwrite = 1'h0;
   logic [2:0]          hsize = 3'h2;
   logic [31:0]         hwdata = 32'h0000_0000;
   wire logic [31:0]    hrdata;
   wire logic           hreadyout;
   wire logic           hresp;
   wire logic           core_req, core_fetch, core_write, core_short, core_data_memory_bus, core_px;
   wire logic [16:0]    core_addr;
   wire logic [47:0]    core_wdata;
   wire logic           core_rvalid;
   wire logic [47:0]    core_rdata;
   wire logic [31:0]    core_reg_data;
   imw_pkg::imw_width_t core_width;
   logic [1:0]          ctrl = 2'h0;
   logic [15:0]         seed = 16'hFEC3;
   logic [15:0]         mem [int];
   imw_exp_t            q [$];
   imw_exp_t            m;
   int                  n_mismatch = 0;
   int                  n_compared = 0;
   int                  cycles = 0;

   imw_mapper dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_req(core_req), .core_fetch(core_fetch),
      .core_write(core_write), .core_short(core_short), .core_data_memory_bus(core_data_memory_bus), .core_px(core_px),
      .core_addr(core_addr), .core_wdata(core_wdata), .core_rvalid(core_rvalid),
      .core_rdata(core_rdata), .core_reg_data(core_reg_data), .core_width(core_width));
   imw_core_model core (.hclk(hclk), .core_req(core_req), .core_fetch(core_fetch),
      .core_write(core_write), .core_short(core_short), .core_data_memory_bus(core_data_memory_bus),
      .core_px(core_px), .core_addr(core_addr), .core_wdata(core_wdata));

   // Clock at 100 MHz
   always #5 hclk = ~hclk;

   // Pseudo random source
   function logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   function int ix(input int c, input int r);
      return c * `IMW_ROWS + r;
   endfunction

   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Single AHB-Lite transfer; read data taken at the data phase edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      core.idle();
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
      chk("hresp", 48'(hresp), 48'h0000_0000_0000);
      if (w && a == 32'h0000_0000) ctrl = wd[1:0];
   endtask

   // Core access, k = {fetch, write, short, data_memory_bus, px}; reference update and read note
   task automatic op(input logic [4:0] k, input logic [16:0] a, input logic [47:0] d);
      imw_pkg::imw_width_t wd;
      logic [15:0] n;
      int          g;
      int          r;
      int          c;
      imw_exp_t    e;
      if (k[4]) wd = imw_pkg::IMW_W48;
      else if (k[2]) wd = imw_pkg::IMW_W16;
      else if (k[0]) wd = k[1] ? imw_pkg::IMW_W40 : imw_pkg::IMW_W48;
      else wd = ctrl[0] ? imw_pkg::IMW_W40 : imw_pkg::IMW_W32;
      n = k[2] ? a[16:1] : a[15:0];
      g = int'(n[15:13]);
      r = int'(n[12:0]);
      e = '0;
      if (wd == imw_pkg::IMW_W16) begin
         c = 2 * g + int'(a[0]);
         if (k[3]) mem[ix(c, r)] = d[31:16];
         e.rd[31:16] = mem[ix(c, r)];
         e.rg = {{16{e.rd[31] & ctrl[1] & ~k[0]}}, e.rd[31:16]};
      end else if (wd == imw_pkg::IMW_W32) begin
         c = 2 * g;
         if (k[3]) {mem[ix(c + 1, r)], mem[ix(c, r)]} = d[47:16];
         e.rd[47:16] = {mem[ix(c + 1, r)], mem[ix(c, r)]};
      end else if (g < 5) begin
         c = 3 * g;
         if (k[3]) {mem[ix(c + 2, r)], mem[ix(c + 1, r)], mem[ix(c, r)]} = d;
         e.rd = {mem[ix(c + 2, r)], mem[ix(c + 1, r)], mem[ix(c, r)]};
         if (wd == imw_pkg::IMW_W40) e.rd[7:0] = 8'h00;
      end
      if (wd != imw_pkg::IMW_W16) e.rg = e.rd[47:16];
      e.w = wd;
      if (!k[3]) q.push_back(e);
      core.access(k, a, d);
   endtask

   // Two writes to a scratch word push earlier writes out to the columns
   task automatic flush();
      op(5'h08, 17'h0_FFFF, 48'h0000_0000_0000);
      op(5'h08, 17'h0_FFFF, 48'h0000_0000_0000);
   endtask

   // Read answers compared against the oldest note
   always @(posedge hclk) begin
      if (hresetn && core_rvalid === 1'h1) begin
         if (q.size() == 0) begin
            n_mismatch++;
            $display("[ERR] core_rvalid expected 0 seen 1");
         end else begin
            m = q.pop_front();
            chk("core_rdata", core_rdata, m.rd);
            chk("core_reg_data", 48'(core_reg_data), 48'(m.rg));
            chk("core_width", 48'(core_width), 48'(m.w));
         end
      end
   end

   // Hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial begin
      logic [31:0] rd;
      logic [15:0] na [8];
      logic [47:0] v;
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      // Reset values, register map, ignored offset
      ahb(1'h0, 32'h0000_0000, 32'h0000_0000, rd);
      chk("ctrl", 48'(rd), 48'h0000_0000_0000);
      ahb(1'h0, 32'h0000_0004, 32'h0000_0000, rd);
      chk("status", 48'(rd), 48'h0000_0000_0001);
      ahb(1'h1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
      ahb(1'h0, 32'h0000_0008, 32'h0000_0000, rd);
      chk("unmapped", 48'(rd), 48'h0000_0000_0000);
      ahb(1'h0, 32'h0000_0000, 32'h0000_0000, rd);
      chk("ctrl", 48'(rd), 48'h0000_0000_0000);
      ahb(1'h1, 32'h0000_0000, 32'h0000_0003, rd);
      ahb(1'h0, 32'h0000_0000, 32'h0000_0000, rd);
      chk("ctrl", 48'(rd), 48'h0000_0000_0003);
      ahb(1'h1, 32'h0000_0000, 32'h0000_0000, rd);
      // 32-bit data in all eight pairs, upper rows only, read back to back then from columns
      for (int g = 0; g < 8; g++) begin
         v = {rnd(), rnd(), rnd()};
         na[g] = {3'(g), 1'h1, v[11:0]};
         op(5'h08, {1'h0, na[g]}, {v[47:16], 16'h0000});
         op(5'h00, {1'h0, na[g]}, v);
      end
      flush();
      // Both shadow entries now hold the scratch writes
      ahb(1'h0, 32'h0000_0004, 32'h0000_0000, rd);
      chk("status", 48'(rd), 48'h0000_0000_0019);
      for (int g = 0; g < 8; g++) op(5'h00, {1'h0, na[g]}, v);
      // Exchange register words on both buses in all groups, lower rows only
      for (int g = 0; g < 8; g++) begin
         v = {rnd(), rnd(), rnd()};
         op(g[0] ? 5'h0B : 5'h09, {1'h0, 3'(g), 13'(g)}, v);
      end
      flush();
      for (int g = 0; g < 8; g++) op(g[0] ? 5'h03 : 5'h10, {1'h0, 3'(g), 13'(g)}, v);
      // Block set for 40-bit data: normal access takes the 48-bit columns
      ahb(1'h1, 32'h0000_0000, 32'h0000_0001, rd);
      v = {rnd(), rnd(), rnd()};
      op(5'h08, 17'h0_4100, v);
      op(5'h08, 17'h0_4101, ~v);
      // Older entry then newer entry served from the shadow buffer
      op(5'h00, 17'h0_4100, v);
      op(5'h00, 17'h0_4101, v);
      flush();
      op(5'h00, 17'h0_4100, v);
      op(5'h00, 17'h0_4101, v);
      // Short words over a 32-bit word, zero fill then sign extend
      ahb(1'h1, 32'h0000_0000, 32'h0000_0000, rd);
      v = {rnd(), rnd(), rnd()};
      op(5'h08, {1'h0, na[3]}, v);
      flush();
      op(5'h04, {na[3], 1'h0}, v);
      op(5'h04, {na[3], 1'h1}, v);
      op(5'h0C, {na[3], 1'h1}, {16'h0000, 1'h1, v[14:0], 16'h0000});
      flush();
      op(5'h00, {1'h0, na[3]}, v);
      ahb(1'h1, 32'h0000_0000, 32'h0000_0002, rd);
      op(5'h04, {na[3], 1'h1}, v);
      op(5'h07, {na[3], 1'h1}, v);
      op(5'h05, {na[3], 1'h1}, v);
      core.idle();
      repeat (4) @(posedge hclk);
      chk("pending", 48'(q.size()), 48'h0000_0000_0000);
      end_sim();
   end
endmodule
